// >>> rtl/bba_unit.sv
module bba_unit (
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 core_hold_i,
   input  wire logic                 irq_pin_i,
   input  wire logic [7:0]           mem_rdata_i,
   input  wire bba_pkg::bba_alu_wb_t alu_wb_i,
   output logic      [12:0]          mem_addr_o,
   output logic                      mem_rd_o,
   output logic                      mem_wr_o,
   output logic      [7:0]           mem_wdata_o,
   output logic                      ea_valid_o,
   output bba_pkg::bba_mode_t        ea_mode_o,
   output logic      [7:0]           ea_opcode_o,
   output logic      [12:0]          operand_address_o,
   output logic      [7:0]           imm_data_o,
   output logic                      ctrl_valid_o,
   output bba_pkg::bba_ctrl_t        ctrl_code_o,
   output bba_pkg::bba_flags_t       flags_o,
   output logic      [7:0]           acc_o,
   output logic      [7:0]           index_o,
   output logic      [12:0]          pc_o,
   output logic      [5:0]           sp_o
);

   bba_pkg::bba_state_t st_q, st_d;
   bba_pkg::bba_mode_t  md_q, md_d, md_new;
   bba_pkg::bba_mode_t  eam_q, eam_d;
   bba_pkg::bba_flags_t flg_q, flg_d;
   bba_pkg::bba_ctrl_t  ctc_q, ctc_d;
   logic [12:0]         pc_q, pc_d;
   logic [12:0]         tgt_q, tgt_d;
   logic [12:0]         ea_q, ea_d;
   logic [5:0]          sp_q, sp_d;
   logic [7:0]          op_q, op_d;
   logic [7:0]          b1_q, b1_d;
   logic [7:0]          b2_q, b2_d;
   logic [7:0]          acc_q, acc_d;
   logic [7:0]          idx_q, idx_d;
   logic [7:0]          eop_q, eop_d;
   logic [7:0]          imm_q, imm_d;
   logic                eav_q, eav_d;
   logic                ctv_q, ctv_d;
   logic                irq_meta_q;
   logic                irq_sync_q;
   logic [7:0]          bit_mask;
   logic                bit_val;

   // Pin level is only ever seen through the second flop
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_meta_q <= 1'b1;
         irq_sync_q <= 1'b1;
      end
      else
      begin
         irq_meta_q <= irq_pin_i;
         irq_sync_q <= irq_meta_q;
      end
   end

   assign md_new   = bba_pkg::mode_of(mem_rdata_i);
   assign bit_mask = 8'h01 << op_q[3:1];
   assign bit_val  = |(mem_rdata_i & bit_mask);

   always_comb
   begin
      st_d        = st_q;
      pc_d        = pc_q;
      sp_d        = sp_q;
      op_d        = op_q;
      md_d        = md_q;
      b1_d        = b1_q;
      b2_d        = b2_q;
      tgt_d       = tgt_q;
      acc_d       = alu_wb_i.acc_we ? alu_wb_i.acc : acc_q;
      idx_d       = alu_wb_i.idx_we ? alu_wb_i.idx : idx_q;
      flg_d       = alu_wb_i.flg_we ? alu_wb_i.flg : flg_q;
      ea_d        = ea_q;
      eam_d       = eam_q;
      eop_d       = eop_q;
      imm_d       = imm_q;
      eav_d       = 1'b0;
      ctv_d       = 1'b0;
      ctc_d       = ctc_q;
      mem_addr_o  = pc_q;
      mem_rd_o    = 1'b0;
      mem_wr_o    = 1'b0;
      mem_wdata_o = 8'h00;
      case (st_q)
         bba_pkg::S_FETCH:
         begin
            // Hold only bites between instructions, so no read is ever in flight
            if (alu_wb_i.pc_we)
            begin
               pc_d = alu_wb_i.pc;
            end
            else if (!core_hold_i)
            begin
               mem_rd_o = 1'b1;
               pc_d     = pc_q + bba_pkg::PC_STEP;
               st_d     = bba_pkg::S_DECODE;
            end
         end
         bba_pkg::S_DECODE:
         begin
            op_d  = mem_rdata_i;
            md_d  = md_new;
            eop_d = mem_rdata_i;
            eam_d = md_new;
            st_d  = bba_pkg::S_FETCH;
            if (mem_rdata_i == bba_pkg::OP_RTS)
            begin
               sp_d       = sp_q + bba_pkg::SP_STEP;
               mem_rd_o   = 1'b1;
               mem_addr_o = bba_pkg::stack_addr(sp_q + bba_pkg::SP_STEP);
               st_d       = bba_pkg::S_POP1;
            end
            else if (bba_pkg::instr_len(md_new) != 2'h1)
            begin
               mem_rd_o = 1'b1;
               pc_d     = pc_q + bba_pkg::PC_STEP;
               st_d     = bba_pkg::S_OPER1;
            end
            else if (md_new == bba_pkg::MD_IX)
            begin
               ea_d  = bba_pkg::page0_addr(idx_q);
               eav_d = 1'b1;
            end
            else
            begin
               case (mem_rdata_i)
                  bba_pkg::OP_ACC_TO_INDEX: idx_d = acc_q;
                  bba_pkg::OP_INDEX_TO_ACC: acc_d = idx_q;
                  bba_pkg::OP_CARRY_SET:    flg_d.c = 1'b1;
                  bba_pkg::OP_CARRY_CLEAR:  flg_d.c = 1'b0;
                  bba_pkg::OP_MASK_SET:     flg_d.i = 1'b1;
                  bba_pkg::OP_MASK_CLEAR:   flg_d.i = 1'b0;
                  bba_pkg::OP_STACK_REINIT: sp_d = bba_pkg::SP_RESET;
                  bba_pkg::OP_IDLE:         st_d = bba_pkg::S_FETCH;
                  bba_pkg::OP_SOFT_TRAP:
                  begin
                     ctv_d = 1'b1;
                     ctc_d = bba_pkg::CT_SOFT_TRAP;
                  end
                  bba_pkg::OP_TRAP_RET:
                  begin
                     ctv_d = 1'b1;
                     ctc_d = bba_pkg::CT_TRAP_RET;
                  end
                  bba_pkg::OP_STOP:
                  begin
                     ctv_d = 1'b1;
                     ctc_d = bba_pkg::CT_STOP;
                  end
                  bba_pkg::OP_WAIT:
                  begin
                     ctv_d = 1'b1;
                     ctc_d = bba_pkg::CT_WAIT;
                  end
                  default:
                  begin
                     ea_d  = pc_q;
                     eav_d = 1'b1;
                  end
               endcase
            end
         end
         bba_pkg::S_OPER1:
         begin
            b1_d = mem_rdata_i;
            st_d = bba_pkg::S_FETCH;
            case (md_q)
               bba_pkg::MD_EXT, bba_pkg::MD_IX2, bba_pkg::MD_BTB:
               begin
                  mem_rd_o = 1'b1;
                  pc_d     = pc_q + bba_pkg::PC_STEP;
                  st_d     = bba_pkg::S_OPER2;
               end
               bba_pkg::MD_REL:
               begin
                  if (op_q == bba_pkg::OP_REL_CALL)
                  begin
                     tgt_d = bba_pkg::rel_target(pc_q, mem_rdata_i);
                     st_d  = bba_pkg::S_PUSH1;
                  end
                  else if (bba_pkg::branch_true(op_q, flg_q, irq_sync_q))
                  begin
                     pc_d = bba_pkg::rel_target(pc_q, mem_rdata_i);
                  end
               end
               bba_pkg::MD_IMM:
               begin
                  ea_d  = pc_q - bba_pkg::PC_STEP;
                  imm_d = mem_rdata_i;
                  eav_d = 1'b1;
               end
               bba_pkg::MD_DIR:
               begin
                  ea_d  = bba_pkg::page0_addr(mem_rdata_i);
                  eav_d = 1'b1;
               end
               bba_pkg::MD_IX1:
               begin
                  // Unsigned sum, so the reach tops out at 510
                  ea_d  = bba_pkg::page0_addr(mem_rdata_i)
                        + bba_pkg::page0_addr(idx_q);
                  eav_d = 1'b1;
               end
               bba_pkg::MD_BSC:
               begin
                  mem_rd_o   = 1'b1;
                  mem_addr_o = bba_pkg::page0_addr(mem_rdata_i);
                  st_d       = bba_pkg::S_DATA;
               end
               default:
               begin
                  st_d = bba_pkg::S_FETCH;
               end
            endcase
         end
         bba_pkg::S_OPER2:
         begin
            b2_d = mem_rdata_i;
            st_d = bba_pkg::S_FETCH;
            case (md_q)
               bba_pkg::MD_EXT:
               begin
                  ea_d  = {b1_q[4:0], mem_rdata_i};
                  eav_d = 1'b1;
               end
               bba_pkg::MD_IX2:
               begin
                  ea_d  = {b1_q[4:0], mem_rdata_i} + bba_pkg::page0_addr(idx_q);
                  eav_d = 1'b1;
               end
               default:
               begin
                  mem_rd_o   = 1'b1;
                  mem_addr_o = bba_pkg::page0_addr(b1_q);
                  st_d       = bba_pkg::S_DATA;
               end
            endcase
         end
         bba_pkg::S_DATA:
         begin
            st_d = bba_pkg::S_FETCH;
            if (md_q == bba_pkg::MD_BSC)
            begin
               // Whole byte goes back, so write-only bits get whatever read returned
               mem_wr_o    = 1'b1;
               mem_addr_o  = bba_pkg::page0_addr(b1_q);
               mem_wdata_o = op_q[0] ? (mem_rdata_i & ~bit_mask)
                                     : (mem_rdata_i | bit_mask);
            end
            else
            begin
               flg_d.c = bit_val;
               if (bit_val ^ op_q[0])
               begin
                  pc_d = bba_pkg::rel_target(pc_q, b2_q);
               end
            end
         end
         bba_pkg::S_PUSH1:
         begin
            mem_wr_o    = 1'b1;
            mem_addr_o  = bba_pkg::stack_addr(sp_q);
            mem_wdata_o = pc_q[7:0];
            sp_d        = sp_q - bba_pkg::SP_STEP;
            st_d        = bba_pkg::S_PUSH2;
         end
         bba_pkg::S_PUSH2:
         begin
            mem_wr_o    = 1'b1;
            mem_addr_o  = bba_pkg::stack_addr(sp_q);
            mem_wdata_o = {3'h0, pc_q[12:8]};
            sp_d        = sp_q - bba_pkg::SP_STEP;
            pc_d        = tgt_q;
            st_d        = bba_pkg::S_FETCH;
         end
         bba_pkg::S_POP1:
         begin
            b1_d       = mem_rdata_i;
            sp_d       = sp_q + bba_pkg::SP_STEP;
            mem_rd_o   = 1'b1;
            mem_addr_o = bba_pkg::stack_addr(sp_q + bba_pkg::SP_STEP);
            st_d       = bba_pkg::S_POP2;
         end
         bba_pkg::S_POP2:
         begin
            pc_d = {b1_q[4:0], mem_rdata_i};
            st_d = bba_pkg::S_FETCH;
         end
         default:
         begin
            st_d = bba_pkg::S_FETCH;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_q  <= bba_pkg::S_FETCH;
         pc_q  <= bba_pkg::PC_RESET;
         sp_q  <= bba_pkg::SP_RESET;
         op_q  <= 8'h00;
         md_q  <= bba_pkg::MD_INH;
         b1_q  <= 8'h00;
         b2_q  <= 8'h00;
         tgt_q <= 13'h0000;
         acc_q <= 8'h00;
         idx_q <= 8'h00;
         flg_q <= bba_pkg::FLAGS_RESET;
         ea_q  <= 13'h0000;
         eam_q <= bba_pkg::MD_INH;
         eop_q <= 8'h00;
         imm_q <= 8'h00;
         eav_q <= 1'b0;
         ctv_q <= 1'b0;
         ctc_q <= bba_pkg::CT_SOFT_TRAP;
      end
      else
      begin
         st_q  <= st_d;
         pc_q  <= pc_d;
         sp_q  <= sp_d;
         op_q  <= op_d;
         md_q  <= md_d;
         b1_q  <= b1_d;
         b2_q  <= b2_d;
         tgt_q <= tgt_d;
         acc_q <= acc_d;
         idx_q <= idx_d;
         flg_q <= flg_d;
         ea_q  <= ea_d;
         eam_q <= eam_d;
         eop_q <= eop_d;
         imm_q <= imm_d;
         eav_q <= eav_d;
         ctv_q <= ctv_d;
         ctc_q <= ctc_d;
      end
   end

   assign ea_valid_o        = eav_q;
   assign ea_mode_o         = eam_q;
   assign ea_opcode_o       = eop_q;
   assign operand_address_o = ea_q;
   assign imm_data_o        = imm_q;
   assign ctrl_valid_o      = ctv_q;
   assign ctrl_code_o       = ctc_q;
   assign flags_o           = flg_q;
   assign acc_o             = acc_q;
   assign index_o           = idx_q;
   assign pc_o              = pc_q;
   assign sp_o              = sp_q;

endmodule : bba_unit

// >>> rtl/bba_pkg.sv
package bba_pkg;

   localparam int          PC_W        = 13;
   localparam logic [12:0] PC_RESET    = 13'h0000;
   localparam logic [12:0] PC_STEP     = 13'h0001;
   localparam logic [6:0]  STACK_PAGE  = 7'h03;
   localparam logic [5:0]  SP_RESET    = 6'h3F;
   localparam logic [5:0]  SP_STEP     = 6'h01;
   localparam logic [4:0]  ZERO_PAGE   = 5'h00;

   // Opcode encodings of the instructions that this unit finishes itself or passes on as control codes
   localparam logic [7:0]  OP_TRAP_RET = 8'h80;
   localparam logic [7:0]  OP_RTS      = 8'h81;
   localparam logic [7:0]  OP_SOFT_TRAP = 8'h83;
   localparam logic [7:0]  OP_STOP     = 8'h8E;
   localparam logic [7:0]  OP_WAIT     = 8'h8F;
   localparam logic [7:0]  OP_ACC_TO_INDEX = 8'h97;
   localparam logic [7:0]  OP_CARRY_CLEAR  = 8'h98;
   localparam logic [7:0]  OP_CARRY_SET    = 8'h99;
   localparam logic [7:0]  OP_MASK_CLEAR   = 8'h9A;
   localparam logic [7:0]  OP_MASK_SET     = 8'h9B;
   localparam logic [7:0]  OP_STACK_REINIT = 8'h9C;
   localparam logic [7:0]  OP_IDLE         = 8'h9D;
   localparam logic [7:0]  OP_INDEX_TO_ACC = 8'h9F;
   localparam logic [7:0]  OP_REL_CALL     = 8'hAD;

   typedef enum logic [3:0] {
      MD_INH = 4'h0,
      MD_IMM = 4'h1,
      MD_DIR = 4'h2,
      MD_EXT = 4'h3,
      MD_REL = 4'h4,
      MD_IX  = 4'h5,
      MD_IX1 = 4'h6,
      MD_IX2 = 4'h7,
      MD_BSC = 4'h8,
      MD_BTB = 4'h9
   } bba_mode_t;

   typedef enum logic [1:0] {
      CT_SOFT_TRAP = 2'h0,
      CT_TRAP_RET  = 2'h1,
      CT_STOP = 2'h2,
      CT_WAIT = 2'h3
   } bba_ctrl_t;

   typedef enum logic [3:0] {
      S_FETCH  = 4'h0,
      S_DECODE = 4'h1,
      S_OPER1  = 4'h3,
      S_OPER2  = 4'h2,
      S_DATA   = 4'h6,
      S_PUSH1  = 4'h7,
      S_PUSH2  = 4'h5,
      S_POP1   = 4'h4,
      S_POP2   = 4'hC
   } bba_state_t;

   typedef struct packed {
      logic h;
      logic i;
      logic n;
      logic z;
      logic c;
   } bba_flags_t;

   localparam bba_flags_t FLAGS_RESET = 5'h08;

   typedef struct packed {
      logic        acc_we;
      logic [7:0]  acc;
      logic        idx_we;
      logic [7:0]  idx;
      logic        flg_we;
      bba_flags_t  flg;
      logic        pc_we;
      logic [12:0] pc;
   } bba_alu_wb_t;

   function automatic bba_mode_t mode_of(input logic [7:0] op);
      bba_mode_t m;
      m = MD_INH;
      case (op[7:4])
         4'h0: m = MD_BTB;
         4'h1: m = MD_BSC;
         4'h2: m = MD_REL;
         4'h3: m = MD_DIR;
         4'h6: m = MD_IX1;
         4'h7: m = MD_IX;
         4'hA: m = (op == OP_REL_CALL) ? MD_REL : MD_IMM;
         4'hB: m = MD_DIR;
         4'hC: m = MD_EXT;
         4'hD: m = MD_IX2;
         4'hE: m = MD_IX1;
         4'hF: m = MD_IX;
         default: m = MD_INH;
      endcase
      return m;
   endfunction : mode_of

   function automatic logic [1:0] instr_len(input bba_mode_t m);
      logic [1:0] n;
      case (m)
         MD_INH, MD_IX:                  n = 2'h1;
         MD_EXT, MD_IX2, MD_BTB:         n = 2'h3;
         default:                        n = 2'h2;
      endcase
      return n;
   endfunction : instr_len

   // Pairs of conditions share opcode[3:1]; opcode[0] inverts the test
   function automatic logic branch_true(input logic [7:0] op, input bba_flags_t f,
                                        input logic irq);
      logic base;
      case (op[3:1])
         3'h0: base = 1'b1;
         3'h1: base = ~f.c & ~f.z;
         3'h2: base = ~f.c;
         3'h3: base = ~f.z;
         3'h4: base = ~f.h;
         3'h5: base = ~f.n;
         3'h6: base = ~f.i;
         3'h7: base = ~irq;
         default: base = 1'b0;
      endcase
      return base ^ op[0];
   endfunction : branch_true

   function automatic logic [12:0] rel_target(input logic [12:0] pc, input logic [7:0] off);
      return pc + {{5{off[7]}}, off};
   endfunction : rel_target

   function automatic logic [12:0] stack_addr(input logic [5:0] sp);
      return {STACK_PAGE, sp};
   endfunction : stack_addr

   function automatic logic [12:0] page0_addr(input logic [7:0] a);
      return {ZERO_PAGE, a};
   endfunction : page0_addr

endpackage : bba_pkg

// >>> dv/bba_mem_model.sv
module bba_mem_model (
   input  wire logic        clk_i,
   input  wire logic [12:0] addr_i,
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] mem [0:8191];

   initial rdata_o = 8'h00;

   // Outside a read answer the bus shows the inverse of its last value, so stale data never
   // passes for a fresh answer
   always @(posedge clk_i)
   begin
      if (wr_i)
         mem[addr_i] <= wdata_i;
      rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
   end
endmodule : bba_mem_model

// >>> dv/bba_unit_asserts.sv
module bba_unit_asserts (
   input wire logic                 core_clk_i,
   input wire logic                 rst_i,
   input wire logic [7:0]           mem_rdata_i,
   input wire bba_pkg::bba_alu_wb_t alu_wb_i,
   input wire logic [12:0]          mem_addr_o,
   input wire logic                 mem_rd_o,
   input wire logic                 mem_wr_o,
   input wire logic [7:0]           mem_wdata_o,
   input wire logic                 ea_valid_o,
   input wire bba_pkg::bba_mode_t   ea_mode_o,
   input wire logic [12:0]          operand_address_o,
   input wire logic [7:0]           index_o,
   input wire logic [12:0]          pc_o
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   AST_RW_EXCL:
   assert property (!(mem_rd_o && mem_wr_o))
      else $error("read and write strobes high together");
   // A write right after a read of the same byte is a read-modify-write of one bit
   AST_RMW_ONE_BIT:
   assert property (mem_wr_o && $past(mem_rd_o) && $past(mem_addr_o) == mem_addr_o
                    |-> $countones(mem_wdata_o ^ mem_rdata_i) <= 1)
      else $error("bit operation changed more than one bit");
   AST_PUSH_PAGE:
   assert property (mem_wr_o && !($past(mem_rd_o) && $past(mem_addr_o) == mem_addr_o)
                    |-> mem_addr_o[12:6] == 7'h03)
      else $error("stack write outside the stack page");
   AST_DIR_PAGE0:
   assert property (ea_valid_o && ea_mode_o == bba_pkg::MD_DIR
                    |-> operand_address_o[12:8] == 5'h00)
      else $error("direct address has a nonzero high part");
   AST_IX_ADDR:
   assert property (ea_valid_o && ea_mode_o == bba_pkg::MD_IX
                    |-> operand_address_o == {5'h00, index_o})
      else $error("indexed address differs from index");
   AST_IX1_REACH:
   assert property (ea_valid_o && ea_mode_o == bba_pkg::MD_IX1
                    |-> operand_address_o <= 13'h01FE && operand_address_o >= {5'h00, index_o})
      else $error("indexed 8-bit offset address out of reach");
   AST_IMM_NEXT:
   assert property (ea_valid_o && ea_mode_o == bba_pkg::MD_IMM
                    |-> operand_address_o == pc_o - 13'h0001)
      else $error("immediate byte is not the one after the opcode");
   AST_EA_KIND:
   assert property (ea_valid_o |-> !(ea_mode_o inside {bba_pkg::MD_REL, bba_pkg::MD_BSC,
                                                      bba_pkg::MD_BTB}) ##1 !ea_valid_o)
      else $error("bad handoff mode or handoff pulse too long");
   AST_PC_STEP:
   assert property (mem_rd_o && mem_addr_o == pc_o && !alu_wb_i.pc_we
                    |=> pc_o == $past(pc_o) + 13'h0001)
      else $error("program counter did not step past the fetched byte");
endmodule : bba_unit_asserts

// >>> dv/bba_unit_tb_top.sv
`define CHK(act, exp) \
   begin \
      samples_checked++; \
      if ((act) !== (exp)) \
      begin \
         n_errors++; \
         $display("CHECK FAILED at %0t: got %0h want %0h", $time, act, exp); \
      end \
   end

module bba_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic                 core_clk_i = 1'b0;
   logic                 rst_i = 1'b1;
   logic                 core_hold_i = 1'b1;
   logic                 irq_pin_i = 1'b1;
   logic [7:0]           mem_rdata_i;
   bba_pkg::bba_alu_wb_t alu_wb_i = '0;
   logic [12:0]          mem_addr_o;
   logic                 mem_rd_o;
   logic                 mem_wr_o;
   logic [7:0]           mem_wdata_o;
   logic                 ea_valid_o;
   bba_pkg::bba_mode_t   ea_mode_o;
   logic [12:0]          operand_address_o;
   logic [7:0]           imm_data_o;
   logic [7:0]           ea_opcode_o;
   logic                 ctrl_valid_o;
   bba_pkg::bba_ctrl_t   ctrl_code_o;
   bba_pkg::bba_flags_t  flags_o;
   logic [7:0]           acc_o;
   logic [7:0]           index_o;
   logic [12:0]          pc_o;
   logic [5:0]           sp_o;
   int                   n_errors = 0;
   int                   samples_checked = 0;
   int                   cycles = 0;
   int                   n_ea = 0;
   int                   n_ct = 0;
   bba_pkg::bba_mode_t   ex_m [7] = '{bba_pkg::MD_DIR, bba_pkg::MD_IMM, bba_pkg::MD_EXT,
                                     bba_pkg::MD_IX, bba_pkg::MD_IX1, bba_pkg::MD_IX2,
                                     bba_pkg::MD_INH};
   logic [12:0]          ex_a [7] = '{13'h0034, 13'h0103, 13'h1ABC, 13'h00FF, 13'h01FE,
                                     13'h1101, 13'h0313};
   logic [7:0]           ex_o [7] = '{8'hB6, 8'hA6, 8'hC6, 8'hF6, 8'hE6, 8'hD6, 8'h4C};
   bba_pkg::bba_ctrl_t   ex_c [4] = '{bba_pkg::CT_SOFT_TRAP, bba_pkg::CT_TRAP_RET,
                                     bba_pkg::CT_STOP, bba_pkg::CT_WAIT};

   bba_unit bba_unit_i (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .core_hold_i(core_hold_i),
      .irq_pin_i(irq_pin_i), .mem_rdata_i(mem_rdata_i), .alu_wb_i(alu_wb_i),
      .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
      .mem_wdata_o(mem_wdata_o), .ea_valid_o(ea_valid_o), .ea_mode_o(ea_mode_o),
      .ea_opcode_o(ea_opcode_o), .operand_address_o(operand_address_o),
      .imm_data_o(imm_data_o), .ctrl_valid_o(ctrl_valid_o), .ctrl_code_o(ctrl_code_o),
      .flags_o(flags_o), .acc_o(acc_o), .index_o(index_o), .pc_o(pc_o), .sp_o(sp_o)
   );

   bba_mem_model bba_mem_model_i (
      .clk_i(core_clk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
      .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i)
   );

   always #2.5 core_clk_i = ~core_clk_i;

   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test

   always @(posedge core_clk_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         stop_test();
      end
   end

   // The first 7 handoffs are compared in order; a stray one from a wrong branch shows up in n_ea
   always @(posedge core_clk_i)
      if (ea_valid_o === 1'b1)
      begin
         if (n_ea < 7)
         begin
            `CHK(ea_mode_o, ex_m[n_ea])
            `CHK(ea_opcode_o, ex_o[n_ea])
            `CHK(operand_address_o, ex_a[n_ea])
            if (ex_m[n_ea] == bba_pkg::MD_IMM)
               `CHK(imm_data_o, 8'h77)
         end
         n_ea++;
      end

   // Control pulses are compared in the order the program issues them
   always @(posedge core_clk_i)
      if (ctrl_valid_o === 1'b1)
      begin
         if (n_ct < 4)
            `CHK(ctrl_code_o, ex_c[n_ct])
         n_ct++;
      end

   task automatic load(input logic [12:0] base, input logic [7:0] b [$]);
      foreach (b[k])
         bba_mem_model_i.mem[base + 13'(k)] = b[k];
   endtask : load

   // Writebacks land while the core is parked in fetch, the only state that takes a new pc from the writeback
   task automatic start(input logic [12:0] target, input logic [7:0] x,
                        input bba_pkg::bba_flags_t f);
      @(posedge core_clk_i);
      alu_wb_i <= {1'b1, 8'h5A, 1'b1, x, 1'b1, f, 1'b1, target};
      @(posedge core_clk_i);
      alu_wb_i <= '0;
      core_hold_i <= 1'b0;
   endtask : start

   task automatic run_to(input logic [12:0] p);
      for (int k = 0; k < 400 && pc_o !== p; k++)
         @(posedge core_clk_i);
      core_hold_i <= 1'b1;
      repeat (8) @(posedge core_clk_i);
   endtask : run_to

   initial
   begin
      load(13'h0100, '{8'hB6, 8'h34, 8'hA6, 8'h77, 8'hC6, 8'h1A, 8'hBC, 8'hF6, 8'hE6, 8'hFF,
                       8'hD6, 8'h10, 8'h02, 8'h14, 8'h40, 8'h1E, 8'h40, 8'h11, 8'h40, 8'h0B,
                       8'h40, 8'h03, 8'h0A, 8'h40, 8'h02, 8'hA6, 8'hEE, 8'h25, 8'h02, 8'hA6,
                       8'hEE, 8'h98, 8'h25, 8'h02, 8'h20, 8'h02, 8'hA6, 8'hEE, 8'h24, 8'h02,
                       8'hA6, 8'hEE, 8'h99, 8'h9B, 8'h2D, 8'h02, 8'hA6, 8'hEE, 8'h2F, 8'h02,
                       8'hA6, 8'hEE, 8'h22, 8'h02, 8'h23, 8'h02, 8'hA6, 8'hEE, 8'h21, 8'h02,
                       8'h20, 8'hFE, 8'hA6, 8'hEE});
      load(13'h02F0, '{8'hAD, 8'h03, 8'h20, 8'hFE, 8'hEE, 8'h2E, 8'h02, 8'hA6, 8'hEE, 8'h9F,
                       8'h81});
      load(13'h0300, '{8'h29, 8'h02, 8'hA6, 8'hEE, 8'h2B, 8'h02, 8'hA6, 8'hEE, 8'h27, 8'h02,
                       8'hA6, 8'hEE, 8'h28, 8'h02, 8'hAD, 8'h00, 8'h9C, 8'h9D, 8'h4C, 8'h83,
                       8'h80, 8'h8E, 8'h8F, 8'h20, 8'hFE});
      bba_mem_model_i.mem[13'h0040] = 8'h21;
      repeat (4) @(posedge core_clk_i);
      rst_i <= 1'b0;
      start(13'h0100, 8'hFF, 5'h00);
      run_to(13'h013D);
      `CHK(pc_o, 13'h013C)
      `CHK(n_ea, 6)
      `CHK(bba_mem_model_i.mem[13'h0040], 8'hA4)
      `CHK(flags_o, 5'h09)
      irq_pin_i <= 1'b0;
      start(13'h02F0, 8'h3C, 5'h00);
      run_to(13'h02F3);
      `CHK(pc_o, 13'h02F2)
      `CHK(n_ea, 6)
      `CHK(sp_o, 6'h3F)
      `CHK(bba_mem_model_i.mem[13'h00FF], 8'hF2)
      `CHK(bba_mem_model_i.mem[13'h00FE], 8'h02)
      `CHK(acc_o, 8'h3C)
      // Half-carry, minus and zero set: the set forms branch, the clear form falls through
      start(13'h0300, 8'h3C, 5'h16);
      run_to(13'h0318);
      `CHK(pc_o, 13'h0317)
      `CHK(n_ea, 7)
      `CHK(n_ct, 4)
      `CHK(sp_o, 6'h3F)
      `CHK(bba_mem_model_i.mem[13'h00FF], 8'h10)
      `CHK(bba_mem_model_i.mem[13'h00FE], 8'h03)
      rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      `CHK(pc_o, 13'h0000)
      rst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      stop_test();
   end
endmodule : bba_unit_tb_top

bind bba_unit bba_unit_asserts bba_unit_asserts_i (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .mem_rdata_i(mem_rdata_i), .alu_wb_i(alu_wb_i),
   .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
   .mem_wdata_o(mem_wdata_o), .ea_valid_o(ea_valid_o), .ea_mode_o(ea_mode_o),
   .operand_address_o(operand_address_o), .index_o(index_o), .pc_o(pc_o)
);
